// ==== rtl/hsk_hop_kernel.sv ====
// hop selection kernel with ahb-lite register slave and frequency bank
//
// Operation
// - fourteen sequence kinds: seven state kinds times 79-hop and 23-hop systems.
// - page phase is a counter-driven one-to-one map onto frequencies.
// - inquiry kinds always use general inquiry LAP plus DCI as address.
// - connection clock is native plus master offset; only 27 MSBs used.
// - page and inquiry use all 28 bits; paging uses peer clock estimate.
// - address input is 28 bits: full lower part plus 4 upper bits.
// - address source follows state: master, paged unit, or inquiry.
// - 79-hop picks 32-frequency segments visited once in pseudorandom order.
// - page substates keep one address-chosen segment the whole time.
// - 23-hop system uses 16-frequency segments.
// - X sets phase, directions pick link way, A-D order, E-F map.
// - datapath order: add, xor, permute, add, bank lookup.
// - first add is phase plus A, modulo 32 or 16.
// - low four sum bits xor address bits 22..19; bit 4 passes.
// - fourteen butterfly stages permute 5 bits or 4 bits.
// - control 0..8 are D; control i+9 is C bit i xor direction.
// - 79-hop butterfly pairs follow the fixed 14-entry list.
// - 23-hop butterfly pairs follow their own fixed 14-entry list.
// - each butterfly is a pair of pass-or-cross multiplexers.
// - second add sums permutation, E, F, direction; modulo 79 or 23.
// - sum indexes 79 or 23 synthesizer code word registers.
// - connection phase is clock 6..2 (5..2); clock bit 1 drives directions.
// - connection A, C, D are address xor clock groups, MSB aligned.
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "hsk_map.svh"
module hsk_hop_kernel #(
  parameter int unsigned tick_cycles = `HSK_TICK_CYC,
  parameter logic [23:0] giac_lap = 24'h00_0000, // arbitrary value
  parameter logic [3:0] dci_low = 4'h0 // arbitrary value
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire hsk_pkg::hsk_ahb_in_t ahb_in,
  output hsk_pkg::hsk_ahb_out_t ahb_out,
  output hsk_pkg::hsk_hop_t hop
);
  import hsk_pkg::*;

  if (tick_cycles < 2 || tick_cycles > 65535) begin : g_bad_tick
    $error("tick_cycles out of range");
  end

  localparam logic [15:0] tick_last = 16'(tick_cycles - 1);
  localparam int lo79 [14] = '{0, 2, 1, 3, 0, 1, 0, 3, 1, 0, 2, 1, 0, 1};
  localparam int hi79 [14] = '{1, 3, 2, 4, 4, 3, 2, 4, 4, 3, 4, 3, 3, 2};
  localparam int lo23 [14] = '{0, 2, 0, 1, 0, 1, 0, 2, 0, 1, 0, 1, 0, 2};
  localparam int hi23 [14] = '{1, 3, 3, 2, 2, 3, 1, 3, 2, 3, 3, 2, 1, 3};

  hsk_state_t st;
  hsk_state_t next_st;

  function automatic hsk_kind_t kind_of(input logic [2:0] f);
    case (f)
      3'h1: kind_of = kind_page;
      3'h2: kind_of = kind_page_resp;
      3'h3: kind_of = kind_inq_scan;
      3'h4: kind_of = kind_inq;
      3'h5: kind_of = kind_inq_resp;
      3'h6: kind_of = kind_conn;
      default: kind_of = kind_page_scan;
    endcase
  endfunction : kind_of

  // one butterfly: two multiplexers cross the pair when ctl is set
  function automatic logic [4:0] bfly(input logic [4:0] v, input logic ctl,
                                      input int lo, input int hi);
    logic [4:0] r;
    r = v;
    if (ctl) begin
      r[lo] = v[hi];
      r[hi] = v[lo];
    end
    return r;
  endfunction : bfly

  // ---------------- kernel inputs, all from registered state
  hsk_kind_t kind;
  logic h23;
  logic is_conn;
  logic is_pagec;
  logic is_inq;
  logic pscan;
  logic [27:0] clk_conn;
  logic [27:0] clk_est;
  logic [27:0] sel_clk;
  logic [27:0] sel_addr;
  logic [4:0] x;
  logic y1;
  logic [4:0] a;
  logic [3:0] b;
  logic [4:0] c;
  logic [8:0] d;
  logic [6:0] e;
  logic [6:0] f;
  logic [24:0] f79_prod;
  logic [24:0] f23_prod;
  logic [4:0] z1;
  logic [4:0] z;
  logic [13:0] pctl;
  logic [4:0] stg [0:14];
  logic [8:0] sum2;
  logic [6:0] y2;
  logic [6:0] idx;

  assign kind = kind_of(st.ctrl[`HSK_CTRL_KIND+:3]);
  assign h23 = st.ctrl[`HSK_CTRL_H23];
  assign is_conn = (kind == kind_conn);
  assign is_pagec = (kind == kind_page) || (kind == kind_page_resp);
  assign is_inq = (kind == kind_inq_scan) || (kind == kind_inq)
                  || (kind == kind_inq_resp);
  assign pscan = (kind == kind_page_scan);

  assign clk_conn = st.native + st.clk_off;
  assign clk_est = st.native + st.est_off;
  // connection drops bit 0; page and inquiry keep all bits
  assign sel_clk = is_conn ? {clk_conn[27:1], 1'b0} :
                   is_pagec ? clk_est : st.native;
  // inquiry never uses a dedicated code for hopping, only the general one
  assign sel_addr = is_inq ? {dci_low, giac_lap} :
                    is_pagec ? st.addr_peer : st.addr_link;

  // page phase comes from software's counter so trains can shift freely
  always_comb begin
    if (is_conn) begin
      x = h23 ? {1'b0, sel_clk[5:2]} : sel_clk[6:2];
    end else if (pscan) begin
      x = h23 ? {1'b0, st.native[15:12]} : st.native[16:12];
    end else begin
      x = st.xphase;
    end
  end

  assign y1 = (pscan || kind == kind_inq_scan) ? 1'b0 : sel_clk[1];
  assign y2 = y1 ? (h23 ? 7'h10 : 7'h20) : 7'h00;

  // only connection slides segments; page keeps address-chosen one
  assign a = sel_addr[27:23] ^ (is_conn ? sel_clk[25:21] : 5'h00);
  assign b = sel_addr[22:19];
  assign c = {sel_addr[8], sel_addr[6], sel_addr[4], sel_addr[2],
              sel_addr[0]} ^ (is_conn ? sel_clk[20:16] : 5'h00);
  assign d = sel_addr[18:10] ^ (is_conn ? sel_clk[15:7] : 9'h000);
  assign e = {sel_addr[13], sel_addr[11], sel_addr[9], sel_addr[7],
              sel_addr[5], sel_addr[3], sel_addr[1]};

  assign f79_prod = {sel_clk[27:7], 4'h0};
  assign f23_prod = 25'(sel_clk[27:6]) * 25'h000_0006;
  always_comb begin
    if (!is_conn) begin
      f = 7'h00;
    end else if (h23) begin
      f = 7'(f23_prod % 25'h000_0017);
    end else begin
      f = 7'(f79_prod % 25'h000_004F);
    end
  end

  // first add wraps in 5 or 4 bits, i.e. modulo 32 or 16
  always_comb begin
    if (h23) begin
      z1 = {1'b0, x[3:0] + a[3:0]};
    end else begin
      z1 = x + a;
    end
  end
  assign z = {h23 ? 1'b0 : z1[4], z1[3:0] ^ b};
  assign pctl = {c ^ {5{y1}}, d};

  // stage g uses control bit 13-g, so the highest pair acts first
  assign stg[0] = z;
  for (genvar g = 0; g < 14; g++) begin : g_bfly
    localparam int j = 13 - g;
    assign stg[g+1] = h23 ? bfly(stg[g], pctl[j], lo23[j], hi23[j])
                          : bfly(stg[g], pctl[j], lo79[j], hi79[j]);
  end

  assign sum2 = 9'(stg[14]) + 9'(e) + 9'(f) + 9'(y2);
  assign idx = h23 ? 7'(sum2 % 9'(`HSK_N23))
                   : 7'(sum2 % 9'(`HSK_N79));

  // ---------------- ahb-lite access decode
  logic acc;
  logic tick_end;
  logic slot_cap;
  logic bank_hit;
  logic [6:0] bank_ix;
  logic [31:0] rd_word;

  assign acc = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
  assign bank_ix = st.dph_addr[8:2];
  assign bank_hit = st.dph_ok && (st.dph_addr[11:9] == `HSK_BANK_TOP)
                    && (st.dph_addr[1:0] == 2'h0) && (bank_ix < `HSK_N79);
  assign tick_end = (st.tick == tick_last);
  // capture the cycle after native turns even, so the new slot's clock
  // feeds the kernel rather than the half slot that just ended
  assign slot_cap = (st.tick == 16'h0000) && !st.native[0];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (bank_hit) begin
      rd_word = 32'(st.bank[bank_ix]);
    end else if (st.dph_ok) begin
      case (st.dph_addr)
        `HSK_CTRL: rd_word = 32'(st.ctrl);
        `HSK_ADDR_LINK: rd_word = 32'(st.addr_link);
        `HSK_ADDR_PEER: rd_word = 32'(st.addr_peer);
        `HSK_CLK_OFF: rd_word = 32'(st.clk_off);
        `HSK_EST_OFF: rd_word = 32'(st.est_off);
        `HSK_XPHASE: rd_word = 32'(st.xphase);
        `HSK_NATIVE: rd_word = 32'(st.native);
        `HSK_STATUS: rd_word = 32'({st.hop.valid, 1'b0, st.hop.index});
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    next_st.tick = tick_end ? 16'h0000 : st.tick + 16'h0001;
    if (tick_end) begin
      next_st.native = st.native + 28'h000_0001;
    end
    if (slot_cap) begin
      next_st.hop.valid = st.ctrl[`HSK_CTRL_EN];
      next_st.hop.index = idx;
      next_st.hop.code = st.bank[idx];
    end
    next_st.bus.hreadyout = 1'b1;
    next_st.bus.hresp = 1'b0;
    next_st.rd_pend = 1'b0;
    next_st.wr_pend = 1'b0;
    // reads wait one cycle so a write just before them is visible
    if (st.rd_pend) begin
      next_st.bus.hrdata = rd_word;
    end
    if (st.wr_pend && bank_hit) begin
      next_st.bank[bank_ix] = ahb_in.hwdata[`HSK_CW-1:0];
    end else if (st.wr_pend && st.dph_ok) begin
      case (st.dph_addr)
        `HSK_CTRL: next_st.ctrl = ahb_in.hwdata[4:0];
        `HSK_ADDR_LINK: next_st.addr_link = ahb_in.hwdata[27:0];
        `HSK_ADDR_PEER: next_st.addr_peer = ahb_in.hwdata[27:0];
        `HSK_CLK_OFF: next_st.clk_off = ahb_in.hwdata[27:0];
        `HSK_EST_OFF: next_st.est_off = ahb_in.hwdata[27:0];
        `HSK_XPHASE: next_st.xphase = ahb_in.hwdata[4:0];
        `HSK_NATIVE: next_st.native = ahb_in.hwdata[27:0];
        default: next_st.native = next_st.native;
      endcase
    end
    if (acc) begin
      next_st.dph_addr = ahb_in.haddr[11:0];
      next_st.dph_ok = (ahb_in.haddr[31:12] == 20'h0_0000);
      next_st.wr_pend = ahb_in.hwrite;
      next_st.rd_pend = !ahb_in.hwrite;
      next_st.bus.hreadyout = ahb_in.hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.bus.hreadyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign ahb_out = st.bus;
  assign hop = st.hop;

  logic [`HSK_CW-1:0] bank_at_idx;
  assign bank_at_idx = st.bank[idx];

  // ---------------- checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_perm_count;
    $countones(stg[14]) == $countones(z);
  endproperty
  a_perm_count: assert property (p_perm_count)
    else $error("permutation lost or gained bits");

  property p_idx_range;
    h23 ? (idx < `HSK_N23) : (idx < `HSK_N79);
  endproperty
  a_idx_range: assert property (p_idx_range)
    else $error("bank index out of range");

  property p_conn_clk;
    is_conn |-> {sel_clk[27:1], st.native[0] ^ st.clk_off[0]}
                == 28'(st.native + st.clk_off);
  endproperty
  a_conn_clk: assert property (p_conn_clk)
    else $error("connection clock wrong");

  property p_inq_addr;
    is_inq |-> sel_addr == {dci_low, giac_lap};
  endproperty
  a_inq_addr: assert property (p_inq_addr)
    else $error("inquiry address not general");

  property p_xor;
    (z[3:0] ^ sel_addr[22:19]) == z1[3:0];
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor stage wrong");

  property p_ctl;
    pctl[8:0] == d && pctl[13:9] == (c ^ {5{y1}});
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("control word wrong");

  property p_h23_top;
    h23 |-> !z[4] && !stg[14][4];
  endproperty
  a_h23_top: assert property (p_h23_top)
    else $error("bit 4 used in 23-hop system");

  property p_slot_hold;
    !slot_cap |=> $stable(hop);
  endproperty
  a_slot_hold: assert property (p_slot_hold)
    else $error("hop output changed inside slot");

  property p_code_lookup;
    slot_cap |=> hop.code == $past(bank_at_idx);
  endproperty
  a_code_lookup: assert property (p_code_lookup)
    else $error("code word not from bank");

  property p_rd_wait;
    acc && !ahb_in.hwrite |=> !ahb_out.hreadyout ##1 ahb_out.hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");

  property p_page_seg;
    !is_conn |-> (a == sel_addr[27:23]) && (d == sel_addr[18:10]);
  endproperty
  a_page_seg: assert property (p_page_seg)
    else $error("segment moved outside connection");

  property p_addr_src;
    is_conn || is_pagec |-> sel_addr == (is_conn ? st.addr_link : st.addr_peer);
  endproperty
  a_addr_src: assert property (p_addr_src)
    else $error("address source wrong for state");

  property p_page_clk;
    is_pagec |-> sel_clk == 28'(st.native + st.est_off);
  endproperty
  a_page_clk: assert property (p_page_clk)
    else $error("page clock not peer estimate");

  property p_valid;
    slot_cap |=> hop.valid == $past(st.ctrl[`HSK_CTRL_EN]);
  endproperty
  a_valid: assert property (p_valid)
    else $error("valid not enable at capture");

  property p_okay;
    ahb_out.hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not okay");

  c_conn79: cover property (slot_cap && is_conn && !h23);
  c_conn23: cover property (slot_cap && is_conn && h23);
  c_page: cover property (slot_cap && is_pagec && y1);
  c_inq: cover property (slot_cap && is_inq);
endmodule : hsk_hop_kernel

// ==== rtl/hsk_map.svh ====
// register offsets, field positions, reset values and timing for hop kernel
`ifndef HSK_MAP_SVH
`define HSK_MAP_SVH
`define HSK_CTRL 12'h000
`define HSK_ADDR_LINK 12'h004
`define HSK_ADDR_PEER 12'h008
`define HSK_CLK_OFF 12'h00C
`define HSK_EST_OFF 12'h010
`define HSK_XPHASE 12'h014
`define HSK_NATIVE 12'h018
`define HSK_STATUS 12'h01C
`define HSK_BANK_TOP 3'h2
`define HSK_CTRL_H23 0
`define HSK_CTRL_KIND 1
`define HSK_CTRL_EN 4
`define HSK_CTRL_RST 32'h0000_0000
`define HSK_STAT_VALID 8
`define HSK_N79 7'h4F
`define HSK_N23 7'h17
`define HSK_CW 16
`define HSK_SLOT_US 625
`define HSK_CLK_NS 50
`define HSK_TICK_CYC ((`HSK_SLOT_US * 1000) / (2 * `HSK_CLK_NS))
`endif

// ==== rtl/hsk_pkg.sv ====
// types shared by the hop selection kernel
package hsk_pkg;
  `include "hsk_map.svh"

  typedef enum logic [2:0] {
    kind_page_scan, kind_page, kind_page_resp, kind_inq_scan,
    kind_inq, kind_inq_resp, kind_conn
  } hsk_kind_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } hsk_ahb_in_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } hsk_ahb_out_t;

  typedef struct packed {
    logic valid;
    logic [6:0] index;
    logic [`HSK_CW-1:0] code;
  } hsk_hop_t;

  typedef struct packed {
    hsk_ahb_out_t bus;
    logic rd_pend;
    logic wr_pend;
    logic dph_ok;
    logic [11:0] dph_addr;
    logic [4:0] ctrl;
    logic [27:0] addr_link;
    logic [27:0] addr_peer;
    logic [27:0] clk_off;
    logic [27:0] est_off;
    logic [4:0] xphase;
    logic [27:0] native;
    logic [15:0] tick;
    logic [78:0][`HSK_CW-1:0] bank;
    hsk_hop_t hop;
  } hsk_state_t;
endpackage : hsk_pkg

// ==== sim/hsk_synth_model.sv ====
// synthesizer model: tunes to the code word the kernel presents in each slot where hop.valid is set
`timescale 1ns/10ps
module hsk_synth_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire hsk_pkg::hsk_hop_t hop,
  output logic [6:0] tuned_freq
);
  import hsk_pkg::*;
  // code words are 0x1000 plus the channel, as the loader writes them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tuned_freq <= 7'h00;
    end else if (hop.valid) begin
      tuned_freq <= 7'(hop.code - 16'h1000);
    end
  end
endmodule : hsk_synth_model

// ==== sim/tb_top.sv ====
// testbench for the hop selection kernel: bus tasks, reference, checks
`timescale 1ns/10ps
`include "hsk_map.svh"
module tb_top;
  import hsk_pkg::*;
  localparam int tc = 4;
  localparam logic [23:0] lap = 24'h5A_3C71; // arbitrary value
  localparam logic [3:0] dci = 4'h9; // arbitrary value
  localparam int p79a[14] = '{0, 2, 1, 3, 0, 1, 0, 3, 1, 0, 2, 1, 0, 1};
  localparam int p79b[14] = '{1, 3, 2, 4, 4, 3, 2, 4, 4, 3, 4, 3, 3, 2};
  localparam int p23a[14] = '{0, 2, 0, 1, 0, 1, 0, 2, 0, 1, 0, 1, 0, 2};
  localparam int p23b[14] = '{1, 3, 3, 2, 2, 3, 1, 3, 2, 3, 3, 2, 1, 3};
  localparam logic [2:0] kinds[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
                                      3'h6};
  logic hclk;
  logic hresetn;
  hsk_ahb_in_t m;
  hsk_ahb_in_t ahb_in;
  hsk_ahb_out_t ahb_out;
  hsk_hop_t hop;
  logic [6:0] tuned_freq;
  int n_errors;
  int cmp_count;
  logic [31:0] rd;
  logic [27:0] a_link, a_peer, c_off, e_off, nat;
  logic [4:0] xph;
  logic [6:0] exp_i;

  always_comb begin
    ahb_in = m;
    ahb_in.hready = ahb_out.hreadyout;
  end
  hsk_hop_kernel #(.tick_cycles(tc), .giac_lap(lap), .dci_low(dci)) uut (
    .hclk(hclk),
    .hresetn(hresetn),
    .ahb_in(ahb_in),
    .ahb_out(ahb_out),
    .hop(hop)
  );
  hsk_synth_model syn (
    .hclk(hclk),
    .hresetn(hresetn),
    .hop(hop),
    .tuned_freq(tuned_freq)
  );
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // samples before the edge's own updates land, as the bus master does
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (ahb_out.hreadyout !== 1'b1 && n < 50);
    if (ahb_out.hreadyout !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d);
    m.haddr <= a;
    m.hwrite <= w;
    m.htrans <= 2'b10;
    wait_rdy();
    m.htrans <= 2'b00;
    m.hwdata <= d;
    wait_rdy();
    rd = ahb_out.hrdata;
    check("hresp", 32'(ahb_out.hresp), 32'h0000_0000);
  endtask : bus

  // even channels first, then odd ones
  function automatic int freq_of(input int i, input logic h);
    int half;
    half = h ? 12 : 40;
    return (i < half) ? 2 * i : 2 * (i - half) + 1;
  endfunction : freq_of

  task automatic load(input logic h);
    for (int i = 0; i < (h ? 23 : 79); i++) begin
      bus(1'b1, 32'h0000_0400 + 32'(4 * i), 32'(16'h1000 + freq_of(i, h)));
    end
  endtask : load

  function automatic logic [6:0] ref_idx(input logic [2:0] k,
      input logic h, input logic [27:0] n);
    logic [27:0] c, ad;
    logic [4:0] x, av, cv, z;
    logic [8:0] dv;
    logic [6:0] ev;
    logic y, p, t;
    int f, s, q;
    c = (k == 3'h6) ? n + (c_off & ~28'h000_0001) :
        (k == 3'h1 || k == 3'h2) ? n + e_off : n;
    ad = (k == 3'h6 || k == 3'h0) ? a_link :
         (k <= 3'h2) ? a_peer : {dci, lap};
    x = (k == 3'h0) ? c[16:12] : (k == 3'h6) ? c[6:2] : xph;
    y = (k == 3'h0 || k == 3'h3) ? 1'b0 : c[1];
    av = ad[27:23];
    cv = {ad[8], ad[6], ad[4], ad[2], ad[0]};
    dv = ad[18:10];
    ev = {ad[13], ad[11], ad[9], ad[7], ad[5], ad[3], ad[1]};
    f = 0;
    if (k == 3'h6) begin
      av ^= c[25:21];
      cv ^= c[20:16];
      dv ^= c[15:7];
      f = h ? (6 * c[27:6]) % 23 : (16 * c[27:7]) % 79;
    end
    z = x + av;
    if (h) z[4] = 1'b0;
    z[3:0] ^= ad[22:19];
    for (int i = 13; i >= 0; i--) begin
      p = (i < 9) ? dv[i] : cv[i - 9] ^ y;
      s = h ? p23a[i] : p79a[i];
      q = h ? p23b[i] : p79b[i];
      if (p) begin
        t = z[s];
        z[s] = z[q];
        z[q] = t;
      end
    end
    q = z + ev + f + (y ? (h ? 16 : 32) : 0);
    return 7'(q % (h ? 23 : 79));
  endfunction : ref_idx

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    n_errors = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    m = '0;
    m.hsel = 1'b1;
    m.hsize = 3'b010;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("hop at reset", {8'h00, hop}, 32'h0000_0000);
    bus(1'b0, `HSK_CTRL, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0000);
    bus(1'b1, `HSK_ADDR_LINK, 32'hFFFF_FFFF);
    bus(1'b0, `HSK_ADDR_LINK, 32'h0000_0000);
    check("addr link", rd, 32'h0FFF_FFFF);
    bus(1'b1, 32'h0000_0800, 32'h1234_5678);
    bus(1'b0, 32'h0000_0800, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    bus(1'b0, 32'h0000_053C, 32'h0000_0000);
    check("bank 79", rd, 32'h0000_0000);
    // fourteen sequence kinds: seven states in both hop systems
    for (int h = 0; h < 2; h++) begin
      load(h[0]);
      bus(1'b0, 32'h0000_0404, 32'h0000_0000);
      check("bank 1", rd, 32'(16'h1000 + freq_of(1, h[0])));
      for (int j = 0; j < 14; j++) begin
        a_link = 28'(32'h0A5C_3E91 * (j + 1));
        a_peer = 28'(32'h0137_9BDF * (j + 3));
        c_off = 28'(32'h0246_8ACF * (j + 5));
        e_off = 28'(32'h0056_789A * (j + 7));
        xph = 5'(j * 7 + h);
        nat = 28'(32'h0F0F_1235 * (j + 1)) | 28'h000_0001;
        bus(1'b1, `HSK_CTRL,
            {27'h0, (j < 9), kinds[j % 7], h[0]});
        bus(1'b1, `HSK_ADDR_LINK, {4'h0, a_link});
        bus(1'b1, `HSK_ADDR_PEER, {4'h0, a_peer});
        bus(1'b1, `HSK_CLK_OFF, {4'h0, c_off});
        bus(1'b1, `HSK_EST_OFF, {4'h0, e_off});
        bus(1'b1, `HSK_XPHASE, {27'h0, xph});
        bus(1'b1, `HSK_NATIVE, {4'h0, nat});
        // one capture lands in the odd-to-even tick, the next is a slot away
        repeat (2 * tc) @(posedge hclk);
        exp_i = ref_idx(kinds[j % 7], h[0], nat + 28'h000_0001);
        check("hop index", 32'(hop.index), 32'(exp_i));
        check("hop code", 32'(hop.code),
              32'(16'h1000 + freq_of(exp_i, h[0])));
        check("hop valid", 32'(hop.valid), 32'(j < 9));
        if (j < 9) check("tuned", 32'(tuned_freq),
                         32'(freq_of(exp_i, h[0])));
        bus(1'b0, `HSK_STATUS, 32'h0000_0000);
        check("status", rd, {23'h0, (j < 9), 1'b0, exp_i});
      end
    end
    give_verdict();
  end
endmodule : tb_top
